/* dv/sfp_plc_model.sv */
// Safe controller model that receives coded diagnostics
`timescale 1ns/1ps
`default_nettype none
module sfp_plc_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        diag_valid,
  input  wire logic [15:0] diag_code,
  input  wire logic [1:0]  diag_chan,
  input  wire logic        diag_is_chan,
  output logic             msg_stb,
  output logic [18:0]      msg
);
  logic        v_q;
  logic [15:0] c_q;
  // A code held over many cycles is one message
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      v_q     <= 1'b0;
      c_q     <= 16'h0000;
      msg_stb <= 1'b0;
      msg     <= 19'h00000;
    end else begin
      v_q     <= diag_valid;
      c_q     <= diag_code;
      msg_stb <= diag_valid && (!v_q || diag_code != c_q);
      msg     <= {diag_is_chan, diag_is_chan ? diag_chan : 2'b00, diag_code};
    end
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for passivation, acknowledge and diagnostics
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfp_pkg::*;
  localparam int DL = 100;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, nv_match_wr, ext_test_en;
  logic selftest_fail, nv_match_in, led_grp_red, led_prot_red, led_prot_green;
  logic diag_valid, diag_is_chan, irq, msg_stb;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, calc_crc, seed, rd;
  logic [3:0]  wstrb, din, discr_fault, proc_out, led_ch_red;
  logic [1:0]  bresp, rresp, diag_chan;
  logic [4:0]  ext_fault;
  logic [15:0] diag_code;
  logic [18:0] msg, exp_q[$];
  int bad_count, cmp_count, n;
  logic [15:0] codes [4] = '{DIAG_DEST, DIAG_CRCLEN, DIAG_PARVER, DIAG_DL_TO};

  sfp_top #(.DL_DELAY(DL), .FLASH_HALF(10), .CRC_W(32)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .din(din),
    .calc_crc(calc_crc), .selftest_fail(selftest_fail), .ext_fault(ext_fault),
    .discr_fault(discr_fault), .nv_match_in(nv_match_in), .nv_match_wr(nv_match_wr),
    .ext_test_en(ext_test_en), .proc_out(proc_out), .led_grp_red(led_grp_red),
    .led_prot_red(led_prot_red), .led_prot_green(led_prot_green),
    .led_ch_red(led_ch_red), .diag_valid(diag_valid), .diag_code(diag_code),
    .diag_chan(diag_chan), .diag_is_chan(diag_is_chan), .irq(irq));

  sfp_plc_model i_plc (.aclk(aclk), .aresetn(aresetn), .diag_valid(diag_valid),
    .diag_code(diag_code), .diag_chan(diag_chan), .diag_is_chan(diag_is_chan),
    .msg_stb(msg_stb), .msg(msg));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready && !aw_ok) begin aw_ok = 1; awvalid <= 0; end
      if (wready && !w_ok) begin w_ok = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge aclk);
    chk(bresp, RESP_OKAY, "write resp");
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    chk(rresp, er, "read resp");
  endtask

  task automatic ack_ok;
    axw(REG_CTRL, 32'h7);
    cyc(3);
    chk(proc_out, din, "real values after ack");
  endtask

  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end

  // Diagnostic messages are matched in arrival order
  always @(posedge aclk) begin
    if (aresetn && msg_stb) begin
      if (exp_q.size() == 0) chk(msg, 19'h7ffff, "unexpected diag");
      else chk(msg, exp_q.pop_front(), "diag message");
    end
  end

  initial begin
    cyc(20000);
    bad_count++;
    summarize();
  end

  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; selftest_fail = 0;
    nv_match_in = 0; ext_fault = 0; discr_fault = 0;
    seed = lfsr(32'h516e1da3);
    din = seed[3:0] | 4'h1;
    calc_crc = lfsr(seed) | 32'h1;
    cyc(6);
    aresetn <= 1;
    axr(REG_STATUS, RESP_OKAY);
    chk(rd[2:0], 3'b010, "passive after reset");
    axw(REG_CTRL, 32'he);
    chk(ext_test_en, 1'b1, "ext test enabled");
    axw(REG_IRQ_MSK, 32'hf);
    axw(REG_CFG_CRC, calc_crc ^ 32'h1);
    axw(REG_CTRL, 32'hf);
    cyc(5);
    chk(proc_out, 4'h0, "substitute on crc mismatch");
    chk(diag_valid, 1'b0, "download diag held back");
    exp_q.push_back({3'b000, DIAG_DL_TO});
    cyc(DL + 20);
    axw(REG_CFG_CRC, calc_crc);
    n = 0;
    while (!nv_match_wr && n < 20) begin cyc(1); n++; end
    chk(nv_match_wr, 1'b1, "match stored");
    n = 0;
    for (int k = 0; k < 60; k++) begin
      rd[0] = led_prot_green;
      cyc(1);
      if (led_prot_green !== rd[0]) n++;
    end
    chk(n >= 4, 1, "green flashing while ack possible");
    ack_ok();
    chk(ext_test_en, 1'b0, "ext test disabled");
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back({3'b000, codes[i]});
      ext_fault <= 5'(1 << i);
      cyc(4);
      chk(proc_out, 4'h0, "passivated on fault");
      chk(led_grp_red, i != 3, "group red");
      chk(led_prot_red, i != 3, "protocol red");
      axw(REG_CTRL, 32'h7);
      cyc(3);
      chk(proc_out, 4'h0, "repassivated on ack");
      ext_fault <= 5'h00;
      cyc(2);
      ack_ok();
    end
    exp_q.push_back({3'b110, DIAG_DISCR});
    discr_fault <= 4'b0100;
    cyc(4);
    chk(led_ch_red, 4'b0100, "channel red");
    chk(led_grp_red, 1'b1, "group red discrepancy");
    discr_fault <= 4'h0;
    cyc(2);
    ack_ok();
    axw(REG_CTRL, 32'h8);
    axw(REG_IRQ_ST, 32'hf);
    chk(irq, 1'b0, "irq idle before fault");
    ext_fault <= 5'h11;
    cyc(6);
    chk(irq, 1'b1, "irq on fault");
    ext_fault <= 5'h00;
    axw(REG_IRQ_ST, 32'hf);
    cyc(1);
    chk(irq, 1'b0, "irq cleared");
    axr(8'h40, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped read data");
    ack_ok();
    selftest_fail <= 1;
    cyc(3);
    selftest_fail <= 0;
    axw(REG_CTRL, 32'h1);
    cyc(3);
    chk(proc_out, 4'h0, "shutdown ignores ack");
    axr(REG_STATUS, RESP_OKAY);
    chk(rd[2:0], 3'b100, "shutdown latched");
    chk(exp_q.size(), 0, "diag messages missing");
    summarize();
  end
endmodule
`default_nettype wire

/* src/sfp_diag_if.sv */
// Interface carrying diagnostic requests into the reporting unit
`timescale 1ns/1ps
`default_nettype none
interface sfp_diag_if;
  logic [5:0]  mod_req;
  logic [3:0]  ch_req;
  logic        ch_en;
  logic        mod_en;
  logic        valid;
  logic [15:0] code;
  logic [1:0]  chan;
  logic        is_chan;
  modport src (output mod_req, output ch_req, output ch_en, output mod_en,
               input valid, input code, input chan, input is_chan);
  modport rep (input mod_req, input ch_req, input ch_en, input mod_en,
               output valid, output code, output chan, output is_chan);
endinterface
`default_nettype wire

/* src/sfp_diag_rep.sv */
// Diagnostic code selector with separate channel and module release
`timescale 1ns/1ps
`default_nettype none
module sfp_diag_rep
  import sfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sfp_diag_if.rep  dif
);
  // Module requests: 0 dest, 1 crclen, 2 parver, 3 download timeout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dif.valid   <= 1'b0;
      dif.code    <= DIAG_NONE;
      dif.chan    <= 2'd0;
      dif.is_chan <= 1'b0;
    end else begin
      dif.valid   <= 1'b1;
      dif.chan    <= 2'd0;
      dif.is_chan <= 1'b0;
      if (dif.mod_en && dif.mod_req[0]) begin
        dif.code <= DIAG_DEST;
      end else if (dif.mod_en && dif.mod_req[1]) begin
        dif.code <= DIAG_CRCLEN;
      end else if (dif.mod_en && dif.mod_req[2]) begin
        dif.code <= DIAG_PARVER;
      end else if (dif.mod_en && dif.mod_req[3]) begin
        dif.code <= DIAG_DL_TO;
      end else if (dif.ch_en && |dif.ch_req) begin
        dif.code    <= DIAG_DISCR;
        dif.is_chan <= 1'b1;
        dif.chan    <= dif.ch_req[0] ? 2'd0 : dif.ch_req[1] ? 2'd1 :
                       dif.ch_req[2] ? 2'd2 : 2'd3;
      end else begin
        dif.valid <= 1'b0;
        dif.code  <= DIAG_NONE;
      end
    end
  end
endmodule
`default_nettype wire

/* src/sfp_pkg.sv */
// Package with register map, diagnostic codes and timing constants
package sfp_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  // Delay before the download diagnostic appears
  localparam int unsigned DL_DELAY_MS     = 270_000;
  localparam longint unsigned DL_DELAY_CYC = longint'(DL_DELAY_MS) * (CLK_HZ / 1000);
  // Acknowledge indicator flash at 0.5 Hz: toggle every second
  localparam int unsigned FLASH_HALF_MS   = 1000;
  localparam longint unsigned FLASH_HALF_CYC = longint'(FLASH_HALF_MS) * (CLK_HZ / 1000);

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CFG_CRC = 8'h04;
  localparam logic [7:0] REG_FAULT   = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_IRQ_ST  = 8'h10;
  localparam logic [7:0] REG_IRQ_MSK = 8'h14;
  localparam logic [7:0] REG_DIAG    = 8'h18;
  localparam logic [7:0] REG_CALC_CRC = 8'h1c;

  // Control bits
  localparam int unsigned CTRL_ACK      = 0;
  localparam int unsigned CTRL_CH_DIAG  = 1;
  localparam int unsigned CTRL_MOD_DIAG = 2;
  // Fault input bits
  localparam int unsigned FLT_DEST   = 0;
  localparam int unsigned FLT_CRCLEN = 1;
  localparam int unsigned FLT_PARVER = 2;
  localparam int unsigned FLT_DL_TO  = 3;
  localparam int unsigned FLT_EXT    = 4;
  // Interrupt bits
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_DIAG  = 1;
  localparam int unsigned IRQ_INT   = 2;
  localparam int unsigned IRQ_MATCH = 3;

  localparam logic [15:0] DIAG_NONE   = 16'h0000;
  localparam logic [15:0] DIAG_DEST   = 16'h0040;
  localparam logic [15:0] DIAG_CRCLEN = 16'h0045;
  localparam logic [15:0] DIAG_PARVER = 16'h0046;
  localparam logic [15:0] DIAG_DL_TO  = 16'h004a;
  localparam logic [15:0] DIAG_DISCR  = 16'h021e;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SFP_RUN  = 3'b001,
    SFP_PASS = 3'b010,
    SFP_SHUT = 3'b100
  } sfp_state_e;
endpackage

/* src/sfp_top.sv */
// Fault passivation, acknowledgement and diagnostics for a 4-input safe module
//
// Summary of operation
// - CRC mismatch gives substitute values
// - CRC match stored in nonvolatile flag
// - Download diagnostic after 4.5 minutes of CRC mismatch, or at once from fault input bit 3
// - Self test and external tests run
// - External fault input (bit 4) passivates but sends no diagnostic
// - Any fault forces all inputs zero
// - Acknowledge possible: green flash 0.5 Hz
// - Acknowledge rechecks; fault present repassivates
// - Internal fault latches, acknowledge ignored
// - Channel and module diagnostics released separately
// - Address mismatch: 0x0040, group and protocol red
// - Discrepancy timeout: 0x021E, channel and group red
// - Bad CRC length: 0x0045, group and protocol red
// - Bad parameter version: 0x0046, both red
// - Download timeout: 0x004A, no indicator
`timescale 1ns/1ps
`default_nettype none
module sfp_top
  import sfp_pkg::*;
#(
  parameter longint unsigned DL_DELAY = DL_DELAY_CYC,
  parameter longint unsigned FLASH_HALF = FLASH_HALF_CYC,
  parameter int unsigned     CRC_W = 32
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        din,
  input  wire logic [CRC_W-1:0]  calc_crc,
  input  wire logic              selftest_fail,
  input  wire logic [4:0]        ext_fault,
  input  wire logic [3:0]        discr_fault,
  input  wire logic              nv_match_in,
  output logic                   nv_match_wr,
  output logic                   ext_test_en,
  output logic [3:0]             proc_out,
  output logic                   led_grp_red,
  output logic                   led_prot_red,
  output logic                   led_prot_green,
  output logic [3:0]             led_ch_red,
  output logic                   diag_valid,
  output logic [15:0]            diag_code,
  output logic [1:0]             diag_chan,
  output logic                   diag_is_chan,
  output logic                   irq
);
  import sfp_pkg::*;

  sfp_state_e       st_q;
  logic [CRC_W-1:0] cfg_crc_q;
  logic [2:0]       ctrl_q;
  logic             ext_test_q;
  logic [3:0]       irq_st_q;
  logic [3:0]       irq_msk_q;
  logic [38:0]      dl_cnt_q;
  logic             dl_diag_q;
  logic [35:0]      fl_cnt_q;
  logic             fl_q;
  logic             nv_match_q;
  logic             ack_pulse;
  logic             crc_bad;
  logic             any_ext;
  logic             fault_now;
  logic [15:0]      last_diag_q;
  sfp_diag_if       dif ();

  // Write channel: take address and data in either order
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        wr_go;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_q      <= 8'h00;
      wd_q      <= 32'h0;
      ws_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return {a[7:2], 2'b00} == r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit(aw_q, REG_CTRL) || hit(aw_q, REG_CFG_CRC) ||
                       hit(aw_q, REG_IRQ_ST) || hit(aw_q, REG_IRQ_MSK)) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Acknowledge is a self-clearing control bit
  assign ack_pulse = wr_go && hit(aw_q, REG_CTRL) && ws_q[0] && wd_q[CTRL_ACK];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= 3'b000;
      ext_test_q <= 1'b1;
      cfg_crc_q  <= '0;
      irq_msk_q  <= 4'h0;
    end else if (wr_go) begin
      if (hit(aw_q, REG_CTRL) && ws_q[0]) begin
        ctrl_q     <= {wd_q[CTRL_MOD_DIAG], wd_q[CTRL_CH_DIAG], 1'b0};
        ext_test_q <= wd_q[3];
      end
      if (hit(aw_q, REG_CFG_CRC)) begin
        for (int i = 0; i < 4; i++) begin
          if (ws_q[i] && 8*i < CRC_W) begin
            cfg_crc_q[8*i +: 8] <= wd_q[8*i +: 8];
          end
        end
      end
      if (hit(aw_q, REG_IRQ_MSK) && ws_q[0]) begin
        irq_msk_q <= wd_q[3:0];
      end
    end
  end
  assign ext_test_en = ext_test_q;

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL:     s_axi_rdata <= {28'h0, ext_test_q, ctrl_q};
        REG_CFG_CRC:  s_axi_rdata <= 32'(cfg_crc_q);
        REG_FAULT:    s_axi_rdata <= {22'h0, discr_fault, selftest_fail, ext_fault};
        REG_STATUS:   s_axi_rdata <= {24'h0, nv_match_q, dl_diag_q, crc_bad,
                                      proc_out == 4'h0, 1'b0, st_q};
        REG_IRQ_ST:   s_axi_rdata <= {28'h0, irq_st_q};
        REG_IRQ_MSK:  s_axi_rdata <= {28'h0, irq_msk_q};
        REG_DIAG:     s_axi_rdata <= {16'h0, last_diag_q};
        REG_CALC_CRC: s_axi_rdata <= 32'(calc_crc);
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Fault evaluation
  assign crc_bad   = (cfg_crc_q != calc_crc) && !nv_match_q;
  assign any_ext   = |ext_fault || |discr_fault;
  assign fault_now = crc_bad || any_ext || selftest_fail;

  // Match flag survives power loss through the external store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_match_q  <= 1'b0;
      nv_match_wr <= 1'b0;
    end else begin
      nv_match_wr <= 1'b0;
      if (nv_match_in) begin
        nv_match_q <= 1'b1;
      end else if (cfg_crc_q == calc_crc && !nv_match_q) begin
        nv_match_q  <= 1'b1;
        nv_match_wr <= 1'b1;
      end
    end
  end

  // Passivation state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= SFP_PASS;
    end else begin
      unique case (st_q)
        SFP_RUN: begin
          if (selftest_fail) st_q <= SFP_SHUT;
          else if (fault_now) st_q <= SFP_PASS;
        end
        SFP_PASS: begin
          if (selftest_fail) st_q <= SFP_SHUT;
          else if (ack_pulse && !fault_now) st_q <= SFP_RUN;
        end
        SFP_SHUT: st_q <= SFP_SHUT;
        default:  st_q <= SFP_SHUT;
      endcase
    end
  end

  // Substitute value zero replaces every input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      proc_out <= 4'h0;
    end else begin
      proc_out <= (st_q == SFP_RUN && !fault_now) ? din : 4'h0;
    end
  end

  // Delayed download diagnostic
  always_ff @(posedge aclk) begin
    if (!aresetn || !crc_bad) begin
      dl_cnt_q  <= '0;
      dl_diag_q <= 1'b0;
    end else if (dl_cnt_q >= 39'(DL_DELAY - 1)) begin
      dl_diag_q <= 1'b1;
    end else begin
      dl_cnt_q <= dl_cnt_q + 39'd1;
    end
  end

  // Green flash while acknowledge could succeed
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q != SFP_PASS) begin
      fl_cnt_q <= '0;
      fl_q     <= 1'b0;
    end else if (fl_cnt_q >= 36'(FLASH_HALF - 1)) begin
      fl_cnt_q <= '0;
      fl_q     <= !fl_q;
    end else begin
      fl_cnt_q <= fl_cnt_q + 36'd1;
    end
  end

  // Indicators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_grp_red    <= 1'b0;
      led_prot_red   <= 1'b0;
      led_prot_green <= 1'b0;
      led_ch_red     <= 4'h0;
    end else begin
      led_prot_red   <= ext_fault[FLT_DEST] | ext_fault[FLT_CRCLEN] |
                        ext_fault[FLT_PARVER];
      led_grp_red    <= ext_fault[FLT_DEST] | ext_fault[FLT_CRCLEN] |
                        ext_fault[FLT_PARVER] | |discr_fault |
                        (st_q == SFP_SHUT);
      led_ch_red     <= discr_fault;
      led_prot_green <= (st_q == SFP_RUN) ? 1'b1 :
                        (st_q == SFP_PASS && !fault_now) ? fl_q : 1'b0;
    end
  end

  // Diagnostic reporting
  assign dif.mod_req = {2'b00, ext_fault[FLT_DL_TO] | dl_diag_q, ext_fault[FLT_PARVER],
                        ext_fault[FLT_CRCLEN], ext_fault[FLT_DEST]};
  assign dif.ch_req  = discr_fault;
  assign dif.ch_en   = ctrl_q[CTRL_CH_DIAG];
  assign dif.mod_en  = ctrl_q[CTRL_MOD_DIAG];

  sfp_diag_rep u_rep (
    .aclk    (aclk),
    .aresetn (aresetn),
    .dif     (dif)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_valid   <= 1'b0;
      diag_code    <= DIAG_NONE;
      diag_chan    <= 2'd0;
      diag_is_chan <= 1'b0;
      last_diag_q  <= DIAG_NONE;
    end else begin
      diag_valid   <= dif.valid;
      diag_code    <= dif.code;
      diag_chan    <= dif.chan;
      diag_is_chan <= dif.is_chan;
      if (dif.valid) last_diag_q <= dif.code;
    end
  end

  // Sticky events; set wins over write-one-to-clear
  logic [3:0] ev;
  logic [3:0] clr;
  assign ev  = {nv_match_wr, st_q == SFP_SHUT, dif.valid && diag_code != dif.code,
                st_q == SFP_RUN && fault_now};
  assign clr = (wr_go && hit(aw_q, REG_IRQ_ST) && ws_q[0]) ? wd_q[3:0] : 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_st_q <= 4'h0;
    else irq_st_q <= (irq_st_q & ~clr) | ev;
  end
  assign irq = |(irq_st_q & irq_msk_q);

  // Checks
  AST_PASS_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_now |=> proc_out == 4'h0) else $error("inputs not passivated");
  AST_CRC_SUBST: assert property (@(posedge aclk) disable iff (!aresetn)
    crc_bad |=> proc_out == 4'h0) else $error("crc mismatch passed data");
  AST_SHUT_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == SFP_SHUT |=> st_q == SFP_SHUT) else $error("shutdown left");
  AST_INT_SHUT: assert property (@(posedge aclk) disable iff (!aresetn)
    selftest_fail |=> st_q == SFP_SHUT) else $error("no shutdown");
  AST_ACK_RECHECK: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == SFP_PASS && ack_pulse && fault_now |=> st_q != SFP_RUN)
    else $error("ack ignored fault");
  AST_HOLD_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == SFP_PASS && !ack_pulse |=> st_q != SFP_RUN)
    else $error("left passivation without ack");
  AST_NV_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    !nv_match_q && !nv_match_in && cfg_crc_q == calc_crc |=> nv_match_wr)
    else $error("match not stored");
  AST_DL_EARLY: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(dl_diag_q) |-> crc_bad && $past(crc_bad, 8)) else $error("download diag early");
  AST_DEST_LED: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_fault[FLT_DEST] |=> led_grp_red && led_prot_red)
    else $error("address leds off");
  AST_CH_LED: assert property (@(posedge aclk) disable iff (!aresetn)
    discr_fault[2] |=> led_ch_red[2] && led_grp_red) else $error("channel led off");
  AST_MOD_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_q[CTRL_MOD_DIAG] && !ctrl_q[CTRL_CH_DIAG] |=> !dif.valid)
    else $error("diag not gated");
  AST_PARVER_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[CTRL_MOD_DIAG] && ext_fault[FLT_PARVER] && !ext_fault[FLT_DEST] &&
    !ext_fault[FLT_CRCLEN] |=> dif.code == DIAG_PARVER) else $error("bad code");
  COV_ACK_OK: cover property (@(posedge aclk) st_q == SFP_PASS ##1 st_q == SFP_RUN);
  COV_SHUT: cover property (@(posedge aclk) st_q == SFP_RUN ##1 st_q == SFP_SHUT);
  COV_CHDIAG: cover property (@(posedge aclk) dif.valid && dif.is_chan);
endmodule
`default_nettype wire
